/* File: hdl/sdbt_ctl_end.sv */
`timescale 1ns/1ps
`default_nettype none
module sdbt_ctl_end #(
  parameter int unsigned CAS_LAT = sdbt_pkg::CAS_LAT,
  parameter int unsigned BURST_LEN = sdbt_pkg::BURST_LEN
) (
  input wire logic clk,
  input wire logic reset_n,
  sdbt_if.ctl bus,
  input wire logic op_valid,
  input wire sdbt_pkg::sdbt_op_t op_kind,
  input wire logic [1:0] op_bank,
  input wire logic [11:0] op_addr,
  input wire logic op_ap,
  input wire logic op_close,
  input wire logic [8:0] op_len,
  output logic op_ready,
  input wire logic [15:0] wdata,
  input wire logic wmask,
  output logic wdata_take,
  output logic [15:0] rdata,
  output logic rdata_valid
);
  localparam bit FULL = (BURST_LEN == sdbt_pkg::PAGE_LEN);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TURN = 2'h1,
    ST_BURST = 2'h3
  } sdbt_ctl_st_t;

  typedef struct packed {
    sdbt_ctl_st_t st;
    logic ready;
    sdbt_pkg::sdbt_op_t kind;
    logic [1:0] bank;
    logic [11:0] addr;
    logic ap;
    logic close;
    logic [8:0] len;
    logic [9:0] cnt;
    logic lead;
    logic rd_recent;
    logic [3:0][3:0] trp;
    logic [CAS_LAT:0] sr;
    logic cs_n;
    sdbt_pkg::sdbt_cmd_t cmd;
    logic [11:0] a;
    logic [1:0] ba;
    logic dqm;
    logic [15:0] dq;
    logic dq_oe;
    logic take;
    logic [15:0] rdata;
    logic rvalid;
  } sdbt_ctl_q_t;

  localparam sdbt_ctl_q_t RST_Q = '{st: ST_IDLE, ready: 1'h1, cs_n: 1'h1,
    cmd: sdbt_pkg::SDBT_CMD_NOP, kind: sdbt_pkg::SDBT_OP_RD, default: '0};

  sdbt_ctl_q_t q;
  sdbt_ctl_q_t next_q;
  logic trunc;
  logic need_lead;
  logic bank_free;
  logic push;

  // Burst is cut short when fewer words are wanted than it holds
  assign trunc = FULL || (q.len < 9'(BURST_LEN));
  // Data mask lead before a write that follows a read
  assign need_lead = (q.kind == sdbt_pkg::SDBT_OP_WR) && q.rd_recent && (BURST_LEN != 1); // RQ18
  // Row precharge time guard per bank
  assign bank_free = (q.kind == sdbt_pkg::SDBT_OP_PRE && q.ap) ? (q.trp == '0) :
    (q.trp[q.bank] == 4'h0); // RQ4

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    next_q = q;
    push = 1'h0;
    next_q.cmd = sdbt_pkg::SDBT_CMD_NOP;
    next_q.dq_oe = 1'h0;
    next_q.take = 1'h0;
    next_q.dqm = 1'h0;
    next_q.rvalid = q.sr[CAS_LAT];
    next_q.rdata = bus.mem_dq;
    for (int b = 0; b < 4; b++)
    begin
      if (q.trp[b] != 4'h0)
        next_q.trp[b] = q.trp[b] - 4'h1;
    end
    case (q.st)
      ST_IDLE:
      begin
        if (op_valid && q.ready)
        begin
          next_q.kind = op_kind;
          next_q.bank = op_bank;
          next_q.addr = op_addr;
          next_q.ap = op_ap;
          next_q.close = op_close & ~op_ap;
          // Fixed burst with auto precharge is never cut short
          next_q.len = (op_ap && !FULL) ? 9'(BURST_LEN) : op_len; // RQ2 RQ6
          next_q.ready = 1'h0;
          next_q.lead = 1'h0;
          next_q.st = ST_TURN;
        end
      end
      ST_TURN:
      begin
        if (bank_free && (q.kind != sdbt_pkg::SDBT_OP_WR || q.sr == '0))
        begin
          if (need_lead && !q.lead)
          begin
            next_q.dqm = 1'h1; // RQ19
            next_q.lead = 1'h1;
          end
          else
          begin
            next_q.dqm = need_lead; // RQ19
            next_q.st = ST_BURST;
            next_q.cnt = 10'h000;
            next_q.take = (q.kind == sdbt_pkg::SDBT_OP_WR);
          end
        end
      end
      ST_BURST:
      begin
        next_q.cnt = q.cnt + 10'h001;
        if (q.cnt == 10'h000)
        begin
          next_q.cs_n = 1'h0;
          next_q.ba = q.bank;
          next_q.a = q.addr;
          if (q.kind != sdbt_pkg::SDBT_OP_ACT)
            next_q.a[sdbt_pkg::AP_BIT] = q.ap; // RQ20
        end
        case (q.kind)
          sdbt_pkg::SDBT_OP_RD:
          begin
            if (q.cnt == 10'h000)
            begin
              next_q.cmd = sdbt_pkg::SDBT_CMD_RD;
              next_q.rd_recent = 1'h1;
            end
            if (q.cnt < {1'h0, q.len})
              push = 1'h1;
            else
            begin
              // End command CAS latency minus one before last data
              if (trunc || q.close)
              begin
                next_q.cmd = q.close ? sdbt_pkg::SDBT_CMD_PRE : sdbt_pkg::SDBT_CMD_BST; // RQ3 RQ7
                next_q.a[sdbt_pkg::AP_BIT] = 1'h0;
                if (q.close)
                  next_q.trp[q.bank] = 4'(sdbt_pkg::TRP_CYC); // RQ4
              end
              if (q.ap)
                next_q.trp[q.bank] = 4'(CAS_LAT + sdbt_pkg::TRP_CYC); // RQ4
              next_q.st = ST_IDLE;
              next_q.ready = 1'h1;
            end
          end
          sdbt_pkg::SDBT_OP_WR:
          begin
            if (q.cnt < {1'h0, q.len})
            begin
              if (q.cnt == 10'h000)
              begin
                next_q.cmd = sdbt_pkg::SDBT_CMD_WR;
                next_q.rd_recent = 1'h0;
              end
              next_q.dq = wdata;
              next_q.dq_oe = 1'h1;
              next_q.dqm = wmask; // RQ1
              next_q.take = (q.cnt + 10'h001 < {1'h0, q.len});
            end
            else if (q.close)
            begin
              // Mask trailing words, precharge after write recovery
              next_q.dqm = trunc; // RQ16
              if (q.cnt == {1'h0, q.len} + 10'(sdbt_pkg::TWR_CYC))
              begin
                next_q.cmd = sdbt_pkg::SDBT_CMD_PRE; // RQ14
                next_q.a[sdbt_pkg::AP_BIT] = 1'h0;
                next_q.trp[q.bank] = 4'(sdbt_pkg::TRP_CYC); // RQ4
                next_q.st = ST_IDLE;
                next_q.ready = 1'h1;
              end
            end
            else
            begin
              if (trunc)
                next_q.cmd = sdbt_pkg::SDBT_CMD_BST; // RQ17
              if (q.ap)
                next_q.trp[q.bank] = 4'(sdbt_pkg::AP_WR_CYC + sdbt_pkg::TRP_CYC); // RQ4
              next_q.st = ST_IDLE;
              next_q.ready = 1'h1;
            end
          end
          sdbt_pkg::SDBT_OP_ACT:
          begin
            next_q.cmd = sdbt_pkg::SDBT_CMD_ACT;
            next_q.st = ST_IDLE;
            next_q.ready = 1'h1;
          end
          default:
          begin
            next_q.cmd = sdbt_pkg::SDBT_CMD_PRE;
            for (int b = 0; b < 4; b++)
            begin
              if (q.ap || q.bank == 2'(b))
                next_q.trp[b] = 4'(sdbt_pkg::TRP_CYC); // RQ4
            end
            next_q.st = ST_IDLE;
            next_q.ready = 1'h1;
          end
        endcase
      end
      default:
      begin
        next_q.st = ST_IDLE;
        next_q.ready = 1'h1;
      end
    endcase
    // Read data arrives CAS latency plus one edges after issue
    next_q.sr = {q.sr[CAS_LAT-1:0], push};
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= RST_Q;
    else
      q <= next_q;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.cs_n = q.cs_n;
  assign {bus.ras_n, bus.cas_n, bus.we_n} = q.cmd;
  assign bus.addr = q.a;
  assign bus.bank_select_inputs = q.ba;
  assign bus.dqm = q.dqm;
  assign bus.ctl_dq = q.dq;
  assign bus.ctl_dq_oe = q.dq_oe;
  assign op_ready = q.ready;
  assign wdata_take = q.take;
  assign rdata = q.rdata;
  assign rdata_valid = q.rvalid;
endmodule // sdbt_ctl_end
`default_nettype wire

/* File: hdl/sdbt_mem_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: Controller lowers mask before write, no latency.
// RQ2: Precharge cuts read unless auto precharge.
// RQ3: Read-ending precharge issued CAS latency minus one early.
// RQ4: No same-bank command until precharge time.
// RQ5: Timed precharge equals auto precharge result.
// RQ6: Burst stop cuts read unless auto precharge.
// RQ7: Read burst stop issued CAS latency minus one early.
// RQ8: Write takes column, bank, auto precharge.
// RQ9: First write word taken with command.
// RQ10: Finished fixed write ignores further data.
// RQ11: Full-page write wraps column to zero.
// RQ12: New write cuts old; data belongs new.
// RQ13: Read stops write data capture at once.
// RQ14: Precharge after write waits write recovery.
// RQ15: Auto precharge waits clock plus recovery.
// RQ16: Mask before and with write-cutting precharge.
// RQ17: Burst stop ignores coincident write data.
// RQ18: Single-word read needs no mask before write.
// RQ19: Mask read output two clocks before write.
// RQ20: Address bit ten selects all-bank precharge.
module sdbt_mem_end #(
  parameter int unsigned CAS_LAT = sdbt_pkg::CAS_LAT,
  parameter int unsigned BURST_LEN = sdbt_pkg::BURST_LEN,
  parameter int unsigned AP_WR_CYC = sdbt_pkg::AP_WR_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  sdbt_if.mem bus,
  output logic illegal_cmd,
  output logic [3:0] bank_open
);
  localparam bit FULL = (BURST_LEN == sdbt_pkg::PAGE_LEN);
  localparam int unsigned PD = CAS_LAT - 1;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] open;
    logic wr_act;
    logic wr_ap;
    logic [1:0] wr_bank;
    logic [7:0] wr_col;
    logic [8:0] wr_left;
    logic rd_act;
    logic rd_ap;
    logic [1:0] rd_bank;
    logic [7:0] rd_col;
    logic [8:0] rd_left;
    logic [PD-1:0] pv;
    logic [PD-1:0][15:0] pd;
    logic dqm_q;
    logic [1:0] ap_bank;
    logic [3:0] ap_cnt;
    logic illegal;
  } sdbt_mem_st_t;

  sdbt_mem_st_t q;
  sdbt_mem_st_t next_q;
  logic [15:0] mem_array [0:1023];
  logic mem_we;
  logic [9:0] mem_wa;
  logic [15:0] fetch;
  sdbt_pkg::sdbt_cmd_t cmd;
  logic [1:0] bs;
  logic c_act;
  logic c_rd;
  logic c_wr;
  logic c_pre;
  logic c_bst;
  logic new_cmd;
  logic all_sel;
  logic rd_lock;
  logic wr_lock;
  logic pre_block;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign cmd = sdbt_pkg::sdbt_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});
  assign bs = bus.bank_select_inputs;
  assign c_act = ~bus.cs_n && (cmd == sdbt_pkg::SDBT_CMD_ACT);
  assign c_rd = ~bus.cs_n && (cmd == sdbt_pkg::SDBT_CMD_RD);
  assign c_wr = ~bus.cs_n && (cmd == sdbt_pkg::SDBT_CMD_WR);
  assign c_pre = ~bus.cs_n && (cmd == sdbt_pkg::SDBT_CMD_PRE);
  assign c_bst = ~bus.cs_n && (cmd == sdbt_pkg::SDBT_CMD_BST);
  assign new_cmd = c_rd | c_wr | c_pre | c_bst;
  assign all_sel = bus.addr[sdbt_pkg::AP_BIT]; // RQ20

  // Fixed bursts with auto precharge may not be cut short
  assign rd_lock = q.rd_act && q.rd_ap && !FULL; // RQ2 RQ6
  assign wr_lock = q.wr_act && q.wr_ap && !FULL; // RQ14
  assign pre_block = (rd_lock && (all_sel || q.rd_bank == bs)) ||
    (wr_lock && (all_sel || q.wr_bank == bs)); // RQ2

  // Array read for the running read burst
  assign fetch = mem_array[{q.rd_bank, q.rd_col}];

  // Arms the auto precharge timer, flushing an older one
  function automatic sdbt_mem_st_t arm_ap(input sdbt_mem_st_t s, input logic [1:0] b);
    sdbt_mem_st_t r;
    r = s;
    if (r.ap_cnt != 4'h0)
      r.open[r.ap_bank] = 1'h0;
    r.ap_bank = b;
    r.ap_cnt = 4'(AP_WR_CYC); // RQ15
    return r;
  endfunction

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  always_comb
  begin
    next_q = q;
    mem_we = 1'h0;
    mem_wa = {q.wr_bank, q.wr_col};
    next_q.illegal = 1'h0;
    next_q.dqm_q = bus.dqm;

    // Auto precharge after write recovery
    if (q.ap_cnt != 4'h0)
    begin
      next_q.ap_cnt = q.ap_cnt - 4'h1;
      if (q.ap_cnt == 4'h1)
        next_q.open[q.ap_bank] = 1'h0; // RQ15
    end

    // Read fetch and column advance
    if (q.rd_act)
    begin
      next_q.rd_col = q.rd_col + 8'h01;
      if (!FULL)
        next_q.rd_left = q.rd_left - 9'h001;
      if (!FULL && q.rd_left == 9'h001)
      begin
        next_q.rd_act = 1'h0;
        if (q.rd_ap)
          next_q.open[q.rd_bank] = 1'h0; // RQ5
      end
    end

    // Read pipeline; its last stage drives the pins at CAS latency
    for (int i = PD - 1; i > 0; i--)
    begin
      next_q.pv[i] = q.pv[i-1];
      next_q.pd[i] = q.pd[i-1];
    end
    next_q.pv[0] = q.rd_act;
    next_q.pd[0] = fetch;
    // Mask held one edge, so output masking lags two clocks
    next_q.pv[PD-1] = next_q.pv[PD-1] & ~q.dqm_q; // RQ19

    // Write burst continues while no new command arrives
    if (q.wr_act && !new_cmd)
    begin
      mem_we = ~bus.dqm; // RQ1
      next_q.wr_col = q.wr_col + 8'h01; // RQ11
      if (!FULL)
        next_q.wr_left = q.wr_left - 9'h001;
      if (!FULL && q.wr_left == 9'h001)
      begin
        next_q.wr_act = 1'h0; // RQ10
        if (q.wr_ap)
          next_q = arm_ap(next_q, q.wr_bank); // RQ8
      end
    end

    // Bank activation
    if (c_act)
      next_q.open[bs] = 1'h1;

    // New write: first word taken on the command edge
    if (c_wr)
    begin
      next_q.rd_act = 1'h0;
      next_q.pv = '0;
      mem_we = ~bus.dqm; // RQ9
      mem_wa = {bs, bus.addr[7:0]}; // RQ12
      next_q.wr_bank = bs; // RQ8
      next_q.wr_col = bus.addr[7:0] + 8'h01;
      next_q.wr_left = 9'(BURST_LEN - 1);
      next_q.wr_ap = all_sel; // RQ8
      next_q.wr_act = (BURST_LEN != 1);
      if (BURST_LEN == 1 && all_sel)
        next_q = arm_ap(next_q, bs);
    end

    // Read ends any write burst at once
    if (c_rd)
    begin
      next_q.wr_act = 1'h0; // RQ13
      next_q.rd_act = 1'h1;
      next_q.rd_bank = bs;
      next_q.rd_col = bus.addr[7:0];
      next_q.rd_left = 9'(BURST_LEN);
      next_q.rd_ap = all_sel;
    end

    // Precharge one bank or all banks
    if (c_pre)
    begin
      if (pre_block)
        next_q.illegal = 1'h1; // RQ2
      else
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (all_sel || bs == 2'(b))
          begin
            next_q.open[b] = 1'h0; // RQ20 RQ5
            if (q.rd_bank == 2'(b))
              next_q.rd_act = 1'h0; // RQ3
            if (q.wr_bank == 2'(b))
              next_q.wr_act = 1'h0; // RQ14
          end
        end
      end
    end

    // Burst stop; coincident write data already dropped above
    if (c_bst)
    begin
      if (rd_lock || wr_lock)
        next_q.illegal = 1'h1; // RQ6
      else
      begin
        next_q.rd_act = 1'h0; // RQ7
        next_q.wr_act = 1'h0; // RQ17
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end

  // Array write port
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem_array[mem_wa] <= bus.ctl_dq;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.mem_dq = q.pd[PD-1];
  assign bus.mem_dq_oe = q.pv[PD-1];
  assign illegal_cmd = q.illegal;
  assign bank_open = q.open;
endmodule // sdbt_mem_end
`default_nettype wire

/* File: inc/sdbt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sdbt_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  logic [1:0] bank_select_inputs;
  logic dqm;
  logic [15:0] ctl_dq;
  logic ctl_dq_oe;
  logic [15:0] mem_dq;
  logic mem_dq_oe;
  // Resolved data wire and a clash flag
  logic [15:0] dq;
  logic dq_clash;
  assign dq = mem_dq_oe ? mem_dq : ctl_dq;
  assign dq_clash = mem_dq_oe & ctl_dq_oe;

  modport ctl (
    output cs_n, ras_n, cas_n, we_n, addr, bank_select_inputs, dqm,
    output ctl_dq, ctl_dq_oe,
    input mem_dq, mem_dq_oe
  );
  modport mem (
    input cs_n, ras_n, cas_n, we_n, addr, bank_select_inputs, dqm,
    input ctl_dq, ctl_dq_oe,
    output mem_dq, mem_dq_oe
  );
endinterface // sdbt_if
`default_nettype wire

/* File: inc/sdbt_pkg.sv */
`default_nettype none
package sdbt_pkg;
  // ----------------------------------------
  // Widths and geometry
  // ----------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned COL_W = 8;
  localparam int unsigned BANKS = 4;
  localparam int unsigned AP_BIT = 10; // Auto precharge / all banks
  localparam int unsigned PAGE_LEN = 256; // Burst length value for full page

  // ----------------------------------------
  // Default mode and timing
  // ----------------------------------------
  localparam int unsigned CAS_LAT = 2;
  localparam int unsigned BURST_LEN = 4;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned TWR_NS = 15;
  localparam int unsigned TRP_NS = 20;
  // Least times round up, never below one cycle
  localparam int unsigned TWR_CYC = ((TWR_NS * CLK_MHZ + 999) / 1000 > 0) ?
    (TWR_NS * CLK_MHZ + 999) / 1000 : 1;
  localparam int unsigned TRP_CYC = ((TRP_NS * CLK_MHZ + 999) / 1000 > 0) ?
    (TRP_NS * CLK_MHZ + 999) / 1000 : 1;
  // Auto precharge waits one full clock plus write recovery
  localparam int unsigned AP_WR_CYC = 1 + TWR_CYC;

  // ----------------------------------------
  // Commands as {ras_n, cas_n, we_n}
  // ----------------------------------------
  typedef enum logic [2:0] {
    SDBT_CMD_MRS = 3'h0,
    SDBT_CMD_REF = 3'h1,
    SDBT_CMD_PRE = 3'h2,
    SDBT_CMD_ACT = 3'h3,
    SDBT_CMD_WR = 3'h4,
    SDBT_CMD_RD = 3'h5,
    SDBT_CMD_BST = 3'h6,
    SDBT_CMD_NOP = 3'h7
  } sdbt_cmd_t;

  // User side operations of the controller end
  typedef enum logic [1:0] {
    SDBT_OP_RD = 2'h0,
    SDBT_OP_WR = 2'h1,
    SDBT_OP_ACT = 2'h2,
    SDBT_OP_PRE = 2'h3
  } sdbt_op_t;
endpackage
`default_nettype wire

/* File: verification/sdbt_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sdbt_checker #(
  parameter int CAS_LAT = sdbt_pkg::CAS_LAT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [1:0] bank_select_inputs,
  input wire logic dqm,
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe,
  input wire logic dq_clash,
  input wire logic illegal_cmd,
  input wire logic [3:0] bank_open
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire logic [2:0] cmd = {ras_n, cas_n, we_n};
  wire logic rd_c = !cs_n && cmd == sdbt_pkg::SDBT_CMD_RD;
  wire logic wr_c = !cs_n && cmd == sdbt_pkg::SDBT_CMD_WR;
  wire logic pre_c = !cs_n && cmd == sdbt_pkg::SDBT_CMD_PRE;
  wire logic bst_c = !cs_n && cmd == sdbt_pkg::SDBT_CMD_BST;
  logic [1:0] ap_bank;
  // Bank of the last auto precharge write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ap_bank <= 2'h0;
    else if (wr_c && addr[sdbt_pkg::AP_BIT])
      ap_bank <= bank_select_inputs;
  end
  // ----------------------------------------
  // Sequences and assertions
  // ----------------------------------------
  sequence s_rd_unmasked;
    rd_c ##(CAS_LAT - 2) !dqm;
  endsequence
  // Timed for a burst of four and a one-cycle write recovery
  sequence s_ap_close;
    bank_open[ap_bank] [*5] ##1 !bank_open[ap_bank];
  endsequence
  no_clash_a: assert property (!dq_clash)
    else $error("data wire driven by both ends");
  rd_latency_a: assert property (s_rd_unmasked |-> ##2 mem_dq_oe)
    else $error("read word missing after cas latency");
  cut_read_a: assert property (pre_c || bst_c |-> ##CAS_LAT !mem_dq_oe)
    else $error("read output runs past a cut");
  wr_drive_a: assert property (wr_c |-> ctl_dq_oe)
    else $error("write command without data");
  wr_quiet_a: assert property (wr_c |-> !mem_dq_oe ##1 !mem_dq_oe)
    else $error("memory drives data during write");
  no_illegal_a: assert property (!illegal_cmd)
    else $error("cut aimed at an auto precharge burst");
  ap_write_a: assert property (wr_c && addr[10] |=> s_ap_close)
    else $error("auto precharge closes at the wrong time");
  pre_one_a: assert property (pre_c && !addr[10] |=> !bank_open[$past(bank_select_inputs)])
    else $error("precharged bank still open");
  pre_all_a: assert property (pre_c && addr[10] |=> bank_open == 4'h0)
    else $error("bank open after all-bank precharge");
endmodule // sdbt_checker
`default_nettype wire

/* File: verification/sdram_burst_truncation_rw_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_truncation_rw_tb;
  logic clk;
  logic reset_n;
  logic op_valid;
  sdbt_pkg::sdbt_op_t op_kind;
  logic [1:0] op_bank;
  logic [11:0] op_addr;
  logic op_ap;
  logic op_close;
  logic [8:0] op_len;
  logic op_ready;
  logic [15:0] wdata;
  logic wmask;
  logic wdata_take;
  logic [15:0] rdata;
  logic rdata_valid;
  logic illegal_cmd;
  logic [3:0] bank_open;
  logic [63:0] wbuf;
  logic [3:0] mbuf;
  logic [15:0] rq [$];
  int wi;
  int bad_count;
  int n_checks;

  sdbt_if sdbt_if_inst ();
  sdbt_ctl_end sdbt_ctl_end_inst (.clk(clk), .reset_n(reset_n), .bus(sdbt_if_inst),
    .op_valid(op_valid), .op_kind(op_kind), .op_bank(op_bank), .op_addr(op_addr),
    .op_ap(op_ap), .op_close(op_close), .op_len(op_len), .op_ready(op_ready),
    .wdata(wdata), .wmask(wmask), .wdata_take(wdata_take), .rdata(rdata),
    .rdata_valid(rdata_valid));
  sdbt_mem_end sdbt_mem_end_inst (.clk(clk), .reset_n(reset_n), .bus(sdbt_if_inst),
    .illegal_cmd(illegal_cmd), .bank_open(bank_open));
  sdbt_checker sdbt_checker_inst (.clk(clk), .reset_n(reset_n), .cs_n(sdbt_if_inst.cs_n),
    .ras_n(sdbt_if_inst.ras_n), .cas_n(sdbt_if_inst.cas_n), .we_n(sdbt_if_inst.we_n),
    .addr(sdbt_if_inst.addr), .bank_select_inputs(sdbt_if_inst.bank_select_inputs),
    .dqm(sdbt_if_inst.dqm), .ctl_dq_oe(sdbt_if_inst.ctl_dq_oe),
    .mem_dq_oe(sdbt_if_inst.mem_dq_oe), .dq_clash(sdbt_if_inst.dq_clash),
    .illegal_cmd(illegal_cmd), .bank_open(bank_open));

  // Clock, 50 ns period
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Write words follow the take strobe; read words are collected
  always @(negedge clk)
  begin
    if (wdata_take === 1'h1)
    begin
      wdata = wbuf[63 - 16 * (wi % 4) -: 16];
      wmask = mbuf[3 - (wi % 4)];
      wi = wi + 1;
    end
    if (rdata_valid === 1'h1)
      rq.push_back(rdata);
  end

  // ----------------------------------------
  // Compare tasks
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits a bounded time for the bank state to settle
  task automatic chk_banks(input logic [3:0] exp);
    int n;
    n = 0;
    while (bank_open !== exp && n < 12)
    begin
      @(negedge clk);
      n++;
    end
    chk_word({12'h000, bank_open}, {12'h000, exp});
  endtask

  // ----------------------------------------
  // Operation tasks
  // ----------------------------------------
  task automatic do_op(input sdbt_pkg::sdbt_op_t k, input logic [1:0] b,
    input logic [11:0] a, input logic ap, input logic cl, input logic [8:0] len);
    int n;
    n = 0;
    @(negedge clk);
    while (op_ready !== 1'h1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    wi = 0;
    op_valid = 1'h1;
    op_kind = k;
    op_bank = b;
    op_addr = a;
    op_ap = ap;
    op_close = cl;
    op_len = len;
    @(negedge clk);
    op_valid = 1'h0;
    n = 0;
    while (op_ready !== 1'h1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk_word(16'(n == 100), 16'h0000);
  endtask

  // Read and compare count and words
  task automatic rd_chk(input logic [1:0] b, input logic [11:0] a, input logic ap,
    input logic cl, input logic [8:0] len, input logic [63:0] e);
    rq.delete();
    do_op(sdbt_pkg::SDBT_OP_RD, b, a, ap, cl, len);
    repeat (sdbt_pkg::CAS_LAT + 3) @(negedge clk);
    chk_word(16'(rq.size()), 16'(len));
    for (int i = 0; i < len; i++)
      chk_word(rq[i], e[63 - 16 * i -: 16]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write_read();
    do_op(sdbt_pkg::SDBT_OP_ACT, 2'h0, 12'h001, 1'h0, 1'h0, 9'h001);
    wbuf = 64'ha0a0_a1a1_a2a2_a3a3;
    mbuf = 4'h0;
    do_op(sdbt_pkg::SDBT_OP_WR, 2'h0, 12'h010, 1'h0, 1'h0, 9'h004);
    rd_chk(2'h0, 12'h010, 1'h0, 1'h0, 9'h004, 64'ha0a0_a1a1_a2a2_a3a3);
    $display("test write_read done");
  endtask

  // Masked word, then burst stop with live data on the stop edge
  task automatic t_mask_bst();
    wbuf = 64'hb0b0_b1b1_b2b2_b3b3;
    mbuf = 4'h4;
    do_op(sdbt_pkg::SDBT_OP_WR, 2'h0, 12'h010, 1'h0, 1'h0, 9'h003);
    rd_chk(2'h0, 12'h010, 1'h0, 1'h0, 9'h004, 64'hb0b0_a1a1_b2b2_a3a3);
    rd_chk(2'h0, 12'h011, 1'h0, 1'h0, 9'h002, 64'ha1a1_b2b2_0000_0000);
    // Fifth word runs past the burst and must be dropped
    wbuf = 64'hf0f0_f1f1_f2f2_f3f3;
    mbuf = 4'h0;
    do_op(sdbt_pkg::SDBT_OP_WR, 2'h0, 12'h00c, 1'h0, 1'h0, 9'h005);
    rd_chk(2'h0, 12'h00f, 1'h0, 1'h0, 9'h002, 64'hf3f3_b0b0_0000_0000);
    $display("test mask_bst done");
  endtask

  // Precharge-closed write up to the page end, then closed read across it
  task automatic t_close();
    do_op(sdbt_pkg::SDBT_OP_ACT, 2'h1, 12'h002, 1'h0, 1'h0, 9'h001);
    wbuf = 64'he0e0_e1e1_e2e2_e3e3;
    mbuf = 4'h0;
    do_op(sdbt_pkg::SDBT_OP_WR, 2'h1, 12'h000, 1'h0, 1'h0, 9'h004);
    wbuf = 64'hc0c0_c1c1_c2c2_c3c3;
    do_op(sdbt_pkg::SDBT_OP_WR, 2'h1, 12'h0fe, 1'h0, 1'h1, 9'h002);
    chk_banks(4'h1);
    do_op(sdbt_pkg::SDBT_OP_ACT, 2'h1, 12'h002, 1'h0, 1'h0, 9'h001);
    rd_chk(2'h1, 12'h0fe, 1'h0, 1'h1, 9'h004, 64'hc0c0_c1c1_e0e0_e1e1);
    chk_banks(4'h1);
    $display("test close done");
  endtask

  // Auto precharge write and read
  task automatic t_auto();
    do_op(sdbt_pkg::SDBT_OP_ACT, 2'h2, 12'h003, 1'h0, 1'h0, 9'h001);
    wbuf = 64'hd0d0_d1d1_d2d2_d3d3;
    mbuf = 4'h0;
    do_op(sdbt_pkg::SDBT_OP_WR, 2'h2, 12'h020, 1'h1, 1'h0, 9'h004);
    chk_banks(4'h1);
    do_op(sdbt_pkg::SDBT_OP_ACT, 2'h2, 12'h003, 1'h0, 1'h0, 9'h001);
    rd_chk(2'h2, 12'h020, 1'h1, 1'h0, 9'h004, 64'hd0d0_d1d1_d2d2_d3d3);
    chk_banks(4'h1);
    $display("test auto done");
  endtask

  // Single-bank then all-bank precharge
  task automatic t_pre_all();
    do_op(sdbt_pkg::SDBT_OP_ACT, 2'h3, 12'h004, 1'h0, 1'h0, 9'h001);
    chk_banks(4'h9);
    do_op(sdbt_pkg::SDBT_OP_PRE, 2'h0, 12'h000, 1'h0, 1'h0, 9'h001);
    chk_banks(4'h8);
    do_op(sdbt_pkg::SDBT_OP_PRE, 2'h1, 12'h000, 1'h1, 1'h0, 9'h001);
    chk_banks(4'h0);
    $display("test pre_all done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'h0;
    op_valid = 1'h0;
    op_kind = sdbt_pkg::SDBT_OP_RD;
    op_bank = 2'h0;
    op_addr = 12'h000;
    op_ap = 1'h0;
    op_close = 1'h0;
    op_len = 9'h001;
    wdata = 16'h0000;
    wmask = 1'h0;
    wbuf = 64'h0;
    mbuf = 4'h0;
    wi = 0;
    bad_count = 0;
    n_checks = 0;
    repeat (4) @(negedge clk);
    reset_n = 1'h1;
    t_write_read();
    t_mask_bst();
    t_close();
    t_auto();
    t_pre_all();
    report_and_stop();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule // sdram_burst_truncation_rw_tb
`default_nettype wire
